/* File: rtl/host_port_defines.svh */
// Purpose: constants of the host register port
// Assumes: included by bare name
// Notes:   definitions only
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH
`define HP_DATA_W 8
`define HP_INDEX_W 8
`define HP_DATA_RST 8'h00
`define HP_INDEX_RST 8'h00
`endif

/* File: rtl/host_port_pkg.sv */
// Purpose: types of the host register port
// Assumes: nothing
// Notes:   access phases of the host bus
package host_port_pkg;
   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_WRITE = 2'b01,
      PH_READ = 2'b10
   } phase_type;
endpackage

/* File: rtl/async_host_register_port.sv */
// Purpose: asynchronous 8-bit host register port with frame kick
// Assumes: strobes asynchronous to clk_in; register file outside
// Notes:   two-stage synchronisers, data piped alongside strobes
`include "host_port_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module async_host_register_port #(
   parameter int DATA_W = `HP_DATA_W,
   parameter int INDEX_W = `HP_INDEX_W
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic host_cs_n_in,
   input wire logic host_rd_n_in,
   input wire logic host_wr_n_in,
   input wire logic [INDEX_W-1:0] host_register_index_in,
   input wire logic [DATA_W-1:0] host_data_bus_in,
   output logic [DATA_W-1:0] host_data_bus_out,
   output logic host_data_bus_oe_out,
   input wire logic frame_kick_in,
   output logic frame_start_out,
   output logic [INDEX_W-1:0] reg_index_out,
   output logic [DATA_W-1:0] reg_wdata_out,
   output logic reg_write_out,
   output logic reg_read_out,
   input wire logic [DATA_W-1:0] reg_rdata_in
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic cs_s1;
      logic cs_s2;
      logic rd_s1;
      logic rd_s2;
      logic wr_s1;
      logic wr_s2;
      logic kick_s1;
      logic kick_s2;
      logic kick_s3;
      logic [DATA_W-1:0] data_p1;
      logic [DATA_W-1:0] data_p2;
      logic [INDEX_W-1:0] idx_p1;
      logic [INDEX_W-1:0] idx_p2;
      host_port_pkg::phase_type phase;
      logic oe;
      logic [DATA_W-1:0] dout;
      logic [INDEX_W-1:0] index;
      logic [DATA_W-1:0] wdata;
      logic wr_pulse;
      logic rd_pulse;
      logic kick_pulse;
   } state_type;

   state_type s_q;
   state_type s_d;
   logic wr_act;
   logic rd_act;

   // ----------------------------------------------------------------
   // decoding
   // ----------------------------------------------------------------
   // a strobe counts only while select is low as well
   function automatic logic qual_low(input logic sel_n, input logic strobe_n);
      return ~sel_n & ~strobe_n;
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   // qualified strobes: select high masks both
   assign wr_act = qual_low(s_q.cs_s2, s_q.wr_s2);
   assign rd_act = qual_low(s_q.cs_s2, s_q.rd_s2);

   always_comb begin
      s_d = s_q;
      // synchronisers and matching data pipe
      s_d.cs_s1 = host_cs_n_in;
      s_d.cs_s2 = s_q.cs_s1;
      s_d.rd_s1 = host_rd_n_in;
      s_d.rd_s2 = s_q.rd_s1;
      s_d.wr_s1 = host_wr_n_in;
      s_d.wr_s2 = s_q.wr_s1;
      s_d.kick_s1 = frame_kick_in;
      s_d.kick_s2 = s_q.kick_s1;
      s_d.kick_s3 = s_q.kick_s2;
      s_d.data_p1 = host_data_bus_in;
      s_d.data_p2 = s_q.data_p1;
      s_d.idx_p1 = host_register_index_in;
      s_d.idx_p2 = s_q.idx_p1;
      s_d.wr_pulse = 1'b0;
      s_d.rd_pulse = 1'b0;
      // rising edge of the kick starts a frame
      s_d.kick_pulse = s_q.kick_s2 & ~s_q.kick_s3;
      case (s_q.phase)
         host_port_pkg::PH_IDLE: begin
            if (wr_act) begin
               s_d.phase = host_port_pkg::PH_WRITE;
               s_d.index = s_q.idx_p2;
               s_d.wdata = s_q.data_p2;
            end else if (rd_act) begin
               // read begins on strobe fall
               s_d.phase = host_port_pkg::PH_READ;
               s_d.index = s_q.idx_p2;
               s_d.rd_pulse = 1'b1;
            end
         end
         host_port_pkg::PH_WRITE: begin
            if (wr_act) begin
               // keep the last value seen while the strobe is low
               s_d.index = s_q.idx_p2;
               s_d.wdata = s_q.data_p2;
            end else begin
               // strobe or select rise ends the write either way
               s_d.wr_pulse = 1'b1;
               s_d.phase = host_port_pkg::PH_IDLE;
            end
         end
         host_port_pkg::PH_READ: begin
            if (!rd_act) begin
               s_d.phase = host_port_pkg::PH_IDLE;
            end
         end
         default: begin
            s_d.phase = host_port_pkg::PH_IDLE;
         end
      endcase
      // bus driven only during a qualified read
      s_d.oe = (s_d.phase == host_port_pkg::PH_READ);
      s_d.dout = s_q.oe ? reg_rdata_in : DATA_W'(`HP_DATA_RST);
   end

   // ----------------------------------------------------------------
   // registers; pin reset returns everything to power-on values
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s_q <= '0;
         s_q.cs_s1 <= 1'b1;
         s_q.cs_s2 <= 1'b1;
         s_q.rd_s1 <= 1'b1;
         s_q.rd_s2 <= 1'b1;
         s_q.wr_s1 <= 1'b1;
         s_q.wr_s2 <= 1'b1;
         s_q.phase <= host_port_pkg::PH_IDLE;
         s_q.index <= INDEX_W'(`HP_INDEX_RST);
         s_q.dout <= DATA_W'(`HP_DATA_RST);
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from flops
   assign host_data_bus_out = s_q.dout;
   assign host_data_bus_oe_out = s_q.oe;
   assign frame_start_out = s_q.kick_pulse;
   assign reg_index_out = s_q.index;
   assign reg_wdata_out = s_q.wdata;
   assign reg_write_out = s_q.wr_pulse;
   assign reg_read_out = s_q.rd_pulse;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);

   a_write_on_rise: assert property (
      (s_q.phase == host_port_pkg::PH_WRITE) && !wr_act |=> reg_write_out)
      else $error("write not issued at strobe rise");
   a_write_needs_phase: assert property (
      reg_write_out |-> $past(s_q.phase) == host_port_pkg::PH_WRITE)
      else $error("write pulse without write phase");
   a_write_one_cycle: assert property (
      reg_write_out |=> !reg_write_out)
      else $error("write pulse longer than one cycle");
   a_read_start: assert property (
      (s_q.phase == host_port_pkg::PH_IDLE) && !wr_act && rd_act |=> reg_read_out)
      else $error("read start missed");
   a_drive_only_read: assert property (
      host_data_bus_oe_out |-> $past(rd_act))
      else $error("bus driven outside a read");
   a_release_on_cs: assert property (
      s_q.cs_s2 |=> !host_data_bus_oe_out)
      else $error("bus not released with select high");
   a_cs_blocks: assert property (
      s_q.cs_s2 && (s_q.phase == host_port_pkg::PH_IDLE) |=> !reg_read_out)
      else $error("strobe acted with select high");
   a_kick_frame: assert property (
      s_q.kick_s2 && !s_q.kick_s3 |=> frame_start_out ##1 !frame_start_out)
      else $error("frame start not one pulse");
   a_sync_delay: assert property (
      s_q.cs_s2 == $past(host_cs_n_in, 2))
      else $error("select synchroniser delay wrong");
   a_read_data: assert property (
      s_q.oe |=> host_data_bus_out == $past(reg_rdata_in))
      else $error("read data not taken from register");
   a_select_ends_write: assert property (
      (s_q.phase == host_port_pkg::PH_WRITE) && s_q.cs_s2 |=> reg_write_out)
      else $error("select rise did not end the write");
   a_reset_idle: assert property (
      $rose(rstn_in) |-> !host_data_bus_oe_out && !reg_write_out)
      else $error("outputs active after reset");

   c_write: cover property (reg_write_out);
   c_read: cover property (reg_read_out ##[1:8] host_data_bus_oe_out);
   c_kick: cover property (frame_start_out);
   c_select_write: cover property ((s_q.phase == host_port_pkg::PH_WRITE) && s_q.cs_s2);
   c_read_release: cover property (host_data_bus_oe_out ##1 !host_data_bus_oe_out);

endmodule // async_host_register_port
`default_nettype wire

/* File: sim/reg_file_model.sv */
// Purpose: register file behind the host port
// Assumes: one write pulse per host write
// Notes: read data follows the index combinationally
`timescale 1ns/1ps
`default_nettype none
module reg_file_model (
   input wire logic clk_in,
   input wire logic reg_write_in,
   input wire logic [7:0] reg_index_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out
);
   logic [7:0] mem_q [256];
   // store each write pulse
   always_ff @(posedge clk_in) begin
      if (reg_write_in) begin
         mem_q[reg_index_in] <= reg_wdata_in;
      end
   end
   // unwritten places stay unknown, so a stray read shows up
   assign reg_rdata_out = mem_q[reg_index_in];
endmodule // reg_file_model
`default_nettype wire

/* File: sim/tb_async_host_register_port.sv */
// Purpose: self-checking bench of the host register port
// Assumes: register file model on the user side
// Notes: host strobes change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module tb_async_host_register_port;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, kick = 1'b0, host_oe = 1'b0;
   logic [7:0] idx = 8'h00, hdat = 8'h00, bus, dout, rdata, ridx, wdata;
   logic oe, fstart, rwr, rrd;
   int n_mismatch = 0, n_checks = 0;
   always #5 clk_in = ~clk_in;
   // bus level from both drivers; a floating bus shows a changing pattern
   assign bus = host_oe ? hdat : (oe ? dout : {4{clk_in, ~clk_in}});
   async_host_register_port dut (.clk_in(clk_in), .rstn_in(rstn_in), .host_cs_n_in(cs_n),
      .host_rd_n_in(rd_n), .host_wr_n_in(wr_n), .host_register_index_in(idx),
      .host_data_bus_in(bus), .host_data_bus_out(dout), .host_data_bus_oe_out(oe),
      .frame_kick_in(kick), .frame_start_out(fstart), .reg_index_out(ridx),
      .reg_wdata_out(wdata), .reg_write_out(rwr), .reg_read_out(rrd), .reg_rdata_in(rdata));
   reg_file_model rf (.clk_in(clk_in), .reg_write_in(rwr), .reg_index_in(ridx),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata));
   task finish_test;
      if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (e !== g) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task step(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   // wait for a write (0), read (1) or frame (2) pulse under a bound
   task wait_pulse(input int sel);
      for (int i = 0; i < 20; i++) begin
         step(1);
         if ((sel == 0 && rwr === 1'b1) || (sel == 1 && rrd === 1'b1)) return;
         if (sel == 2 && fstart === 1'b1) return;
      end
      n_mismatch++;
      $display("unexpected pulse expected 1 seen 0");
      finish_test();
   endtask
   // write with select held low or toggled with the strobe
   task host_write(input logic [7:0] a, input logic [7:0] d, input bit tog);
      idx = a; hdat = d; host_oe = 1'b1; cs_n = 1'b0;
      if (!tog) step(1);
      wr_n = 1'b0; step(4);
      wr_n = 1'b1; if (tog) cs_n = 1'b1;
      wait_pulse(0);
      chk("write index", a, ridx);
      chk("write data", d, wdata);
      cs_n = 1'b1; host_oe = 1'b0; step(4);
   endtask
   // read with select toggled together with the strobe
   task host_read(input logic [7:0] a, input logic [7:0] e);
      idx = a; cs_n = 1'b0; rd_n = 1'b0;
      wait_pulse(1);
      chk("read enable", 8'h01, {7'h00, oe});
      step(1);
      chk("read data", e, bus);
      cs_n = 1'b1; rd_n = 1'b1; step(4);
      chk("released enable", 8'h00, {7'h00, oe});
   endtask
   // deselected strobes must do nothing, neither while low nor after they rise
   task ignored_strobes;
      rd_n = 1'b0;
      for (int i = 0; i < 12; i++) begin
         if (i == 4) begin
            rd_n = 1'b1;
            wr_n = 1'b0;
         end
         if (i == 8) wr_n = 1'b1;
         step(1);
         chk("deselected", 8'h00, {5'h00, oe, rwr, rrd});
      end
      step(4);
   endtask
   // one frame start per rising kick, none while it stays high
   task frame_kick;
      kick = 1'b1; wait_pulse(2);
      for (int i = 0; i < 6; i++) begin
         step(1);
         chk("frame start", 8'h00, {7'h00, fstart});
      end
      kick = 1'b0; step(4);
   endtask
   // reset in mid-read clears all outputs at once
   task mid_reset;
      idx = 8'h3c; cs_n = 1'b0; rd_n = 1'b0; step(6);
      rstn_in = 1'b0;
      cs_n = 1'b1;
      rd_n = 1'b1;
      #1;
      chk("reset outputs", 8'h00, {4'h0, oe, rwr, rrd, fstart});
      chk("reset data", 8'h00, dout);
      step(3);
      rstn_in = 1'b1; step(2);
   endtask
   // main sequence
   initial begin
      step(16);
      rstn_in = 1'b1; step(2);
      host_write(8'h3c, 8'ha5, 1'b0);
      host_write(8'hc3, 8'h5a, 1'b1);
      host_read(8'h3c, 8'ha5);
      host_read(8'hc3, 8'h5a);
      ignored_strobes();
      frame_kick();
      mid_reset();
      host_read(8'hc3, 8'h5a);
      finish_test();
   end
endmodule // tb_async_host_register_port
`default_nettype wire
